/* File: rtl/flash_guard.sv */
// Purpose: guards program flash against unwanted read, write and erase
// Assumes: core gives one request at a time, held until CORE_DONE
// Notes:   flash array modelled as an external port with a strobe each
// Summary of operation
// R1: writes need program store write enable set
// R2: erase needs both write and erase enables
// R3: data-space writes store flash; code reads return it
// R4: data-space reads always go to external RAM
// R5: lock value comes from last user flash byte
// R6: lock counts 512-byte pages from page zero
// R7: locked page count is inverted lock byte
// R8: lock page open only when lock byte all ones
// R9: debug port cannot read or change locked flash
// R10: refused write or erase leaves flash unchanged
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int ADDR_W    = `FG_ADDR_W,
  parameter int ERASE_CYC = `FG_ERASE_CYCLES,
  parameter int WRITE_CYC = `FG_WRITE_CYCLES
)
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // software enables
  input  wire logic              PROGRAM_STORE_WRITE_ENABLE,
  input  wire logic              PROGRAM_STORE_ERASE_ENABLE,
  // core request
  input  wire logic              CORE_REQ,
  input  wire logic [1:0]        CORE_KIND,
  input  wire logic              CORE_DATA_SPACE,
  input  wire logic              CORE_FROM_PROTECTED,
  input  wire logic              CORE_FROM_DEBUG,
  input  wire logic [ADDR_W-1:0] CORE_ADDR,
  input  wire logic [7:0]        CORE_WDATA,
  output logic                   CORE_DONE,
  output logic                   CORE_REFUSED,
  output logic [7:0]             CORE_RDATA,
  // external data RAM route
  output logic                   XDATA_RD,
  output logic [ADDR_W-1:0]      XDATA_ADDR,
  // flash array side
  output logic                   FLASH_RD,
  output logic                   FLASH_WR,
  output logic                   FLASH_ER,
  output logic [ADDR_W-1:0]      FLASH_ADDR,
  output logic [7:0]             FLASH_WDATA,
  input  wire logic [7:0]        FLASH_RDATA,
  // state seen outside
  output logic [7:0]             LOCK_VALUE
);
  // refuse sizes the page split and the 8-bit busy counter cannot serve
  if (ADDR_W < 10 || ADDR_W > 24 || ERASE_CYC < 1 || WRITE_CYC < 1 || ERASE_CYC > 255 || WRITE_CYC > 255)
  begin : g_bad_params
    $error("flash_guard: unsupported parameters");
  end

  localparam logic [ADDR_W-1:0] LOCK_ADDR = {ADDR_W{1'b1}}; // last user byte

  lock_if #(.ADDR_W(ADDR_W)) lk ();

  lock_check #(.ADDR_W(ADDR_W)) u_lock
  (
    .lk        (lk),
    .lock_addr (LOCK_ADDR)
  );

  guard_state_e      state_q, state_d;     // sequencer state
  logic [7:0]        cnt_q, cnt_d;         // busy cycle count
  logic [7:0]        lock_q, lock_d;       // held lock byte
  logic              done_q, done_d;       // answer strobe
  logic              ref_q, ref_d;         // refused flag with answer
  logic [7:0]        rdat_q, rdat_d;       // read data back
  logic              xrd_q, xrd_d;         // external RAM read strobe
  logic              frd_q, frd_d;         // flash read strobe
  logic              fwr_q, fwr_d;         // flash write strobe
  logic              fer_q, fer_d;         // flash erase strobe
  logic [ADDR_W-1:0] addr_q, addr_d;       // latched address
  logic [7:0]        wdat_q, wdat_d;       // latched write byte
  logic              trusted;              // requester may touch locked pages

  // lock query always looks at the incoming address
  assign lk.lock_byte = lock_q;
  assign lk.addr      = CORE_ADDR;
  assign trusted      = CORE_FROM_PROTECTED && !CORE_FROM_DEBUG;

  // next-state logic of the access sequencer
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    lock_d  = lock_q;
    done_d  = 1'b0;
    ref_d   = 1'b0;
    rdat_d  = rdat_q;
    xrd_d   = 1'b0;
    frd_d   = 1'b0;
    fwr_d   = 1'b0;
    fer_d   = 1'b0;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    case (state_q)
      // fetch lock byte after reset
      ST_IDLE:
      begin
        addr_d  = LOCK_ADDR; // R5
        frd_d   = 1'b1;
        state_d = ST_LOAD;
      end
      // capture lock byte once the array answers
      ST_LOAD:
      begin
        if (!frd_q)
        begin
          lock_d  = FLASH_RDATA; // R5
          state_d = ST_DONE;
        end
      end
      // ready: wait for a request
      ST_DONE:
      begin
        if (CORE_REQ && !done_q)
        begin
          addr_d = CORE_ADDR;
          wdat_d = CORE_WDATA;
          case (req_kind_e'(CORE_KIND))
            REQ_READ:
            begin
              if (CORE_DATA_SPACE)
              begin
                xrd_d  = 1'b1; // R4
                done_d = 1'b1;
              end
              else if (lk.locked && !trusted)
              begin
                rdat_d = 8'h00; // R9
                ref_d  = 1'b1;
                done_d = 1'b1;
              end
              else
              begin
                frd_d   = 1'b1; // R3
                state_d = ST_READ;
              end
            end
            REQ_WRITE:
            begin
              if (!PROGRAM_STORE_WRITE_ENABLE || !CORE_DATA_SPACE || (lk.locked && !trusted))
              begin
                ref_d  = 1'b1; // R1 R9 R10
                done_d = 1'b1;
              end
              else
              begin
                fwr_d   = 1'b1; // R3
                cnt_d   = 8'(WRITE_CYC);
                state_d = ST_WRITE;
              end
            end
            REQ_ERASE:
            begin
              if (!PROGRAM_STORE_WRITE_ENABLE || !PROGRAM_STORE_ERASE_ENABLE || (lk.locked && !trusted))
              begin
                ref_d  = 1'b1; // R2 R9 R10
                done_d = 1'b1;
              end
              else
              begin
                fer_d   = 1'b1; // R2
                cnt_d   = 8'(ERASE_CYC);
                state_d = ST_ERASE;
              end
            end
            default:
            begin
              done_d = 1'b1;
            end
          endcase
        end
      end
      // array answers in the cycle after the strobe, as for the lock fetch
      ST_READ:
      begin
        if (!frd_q)
        begin
          rdat_d  = FLASH_RDATA; // R3
          done_d  = 1'b1;
          state_d = ST_DONE;
        end
      end
      // write and erase: busy countdown, reload lock if the address lies in the lock page
      ST_WRITE, ST_ERASE:
      begin
        if (cnt_q <= 8'h01)
        begin
          done_d = 1'b1;
          if ((addr_q >> `FG_PAGE_SHIFT) == (LOCK_ADDR >> `FG_PAGE_SHIFT))
            state_d = ST_IDLE; // R5
          else
            state_d = ST_DONE;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // register stage of the sequencer
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
      lock_q  <= 8'h00;
      done_q  <= 1'b0;
      ref_q   <= 1'b0;
      rdat_q  <= 8'h00;
      xrd_q   <= 1'b0;
      frd_q   <= 1'b0;
      fwr_q   <= 1'b0;
      fer_q   <= 1'b0;
      addr_q  <= '0;
      wdat_q  <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      lock_q  <= lock_d;
      done_q  <= done_d;
      ref_q   <= ref_d;
      rdat_q  <= rdat_d;
      xrd_q   <= xrd_d;
      frd_q   <= frd_d;
      fwr_q   <= fwr_d;
      fer_q   <= fer_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
    end
  end

  // outputs straight from flops
  assign CORE_DONE    = done_q;
  assign CORE_REFUSED = ref_q;
  assign CORE_RDATA   = rdat_q;
  assign XDATA_RD     = xrd_q;
  assign XDATA_ADDR   = addr_q;
  assign FLASH_RD     = frd_q;
  assign FLASH_WR     = fwr_q;
  assign FLASH_ER     = fer_q;
  assign FLASH_ADDR   = addr_q;
  assign FLASH_WDATA  = wdat_q;
  assign LOCK_VALUE   = lock_q;
endmodule

/* File: include/flash_guard_defs.svh */
// Purpose: constants for the flash write guard and lock block
// Assumes: byte-addressed program flash, 512-byte pages
// Notes:   included by bare name; definitions only
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH
`define FG_ADDR_W        17
`define FG_PAGE_SHIFT    9
`define FG_PAGE0_FIRST   17'h0_0000
`define FG_PAGE0_LAST    17'h0_01FF
`define FG_LOCK_OPEN     8'hFF
`define FG_ERASE_CYCLES  8
`define FG_WRITE_CYCLES  2
`endif

/* File: include/flash_guard_pkg.sv */
// Purpose: shared types of the flash write guard and lock block
// Assumes: nothing beyond the defs header
// Notes:   states of the access sequencer and request kinds
package flash_guard_pkg;
  typedef enum logic [1:0]
  {
    REQ_NONE  = 2'b00,
    REQ_READ  = 2'b01,
    REQ_WRITE = 2'b10,
    REQ_ERASE = 2'b11
  } req_kind_e;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_LOAD   = 3'b001,
    ST_READ   = 3'b010,
    ST_WRITE  = 3'b011,
    ST_ERASE  = 3'b100,
    ST_DONE   = 3'b101
  } guard_state_e;
endpackage

/* File: include/lock_if.sv */
// Purpose: carries the lock decision between guard and lock checker
// Assumes: single clock
// Notes:   the guard asks, the checker answers combinationally
`timescale 1ns/1ps
interface lock_if #(parameter int ADDR_W = 17);
  logic [7:0]        lock_byte;  // lock value as held
  logic [ADDR_W-1:0] addr;       // address asked about
  logic              locked;     // address lies in a locked page
  modport guard (output lock_byte, output addr, input locked);
  modport check (input lock_byte, input addr, output locked);
endinterface

/* File: rtl/lock_check.sv */
// Purpose: decides whether a flash address sits in a locked page
// Assumes: lock byte lives in the last byte of user flash
// Notes:   pure combinational decision
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module lock_check
  import flash_guard_pkg::*;
#(
  parameter int ADDR_W = `FG_ADDR_W
)
(
  // lock query
  lock_if.check           lk,
  // location of the lock byte
  input  wire logic [ADDR_W-1:0] lock_addr
);
  logic [7:0]        pages_n;    // number of locked low pages
  logic [ADDR_W-1:0] page_idx;   // page index of queried address
  logic [ADDR_W-1:0] lock_page;  // page index of the lock byte

  // page count is the inverted lock byte; lock page closes if any page locked
  always_comb
  begin
    pages_n   = ~lk.lock_byte; // R7
    page_idx  = lk.addr >> `FG_PAGE_SHIFT; // R6
    lock_page = lock_addr >> `FG_PAGE_SHIFT;
    if (lk.lock_byte == `FG_LOCK_OPEN)
      lk.locked = 1'b0; // R8
    else if (page_idx == lock_page)
      lk.locked = 1'b1; // R8
    else
      lk.locked = (page_idx < ADDR_W'(pages_n)); // R6
  end
endmodule

/* File: bench/flash_model.sv */
// Purpose: program flash array behind the guard
// Assumes: read data one cycle after the read strobe
// Notes:   between reads the data lines toggle
`timescale 1ns/1ps
module flash_model #(parameter logic [7:0] LOCK = 8'hFD)
(
  // strobes from guard
  input  wire logic        CLK,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  wdata,
  // array data
  output logic [7:0]       rdata = 8'h00
);
  int mem [int];  // bytes written so far
  // store writes, answer reads, toggle when idle
  always @(posedge CLK)
  begin
    if (wr) mem[addr] = wdata;
    if (rd) rdata <= addr == 17'h1_FFFF ? LOCK : mem.exists(addr) ? 8'(mem[addr]) : addr[7:0] ^ 8'h5A;
    else rdata <= ~rdata;
  end
endmodule

/* File: bench/flash_guard_checker.sv */
// Purpose: port checks of the flash guard
// Assumes: one clock, sync reset
// Notes:   bound to every flash_guard
`timescale 1ns/1ps
module flash_guard_checker #(parameter int ADDR_W = 17, parameter int WRITE_CYC = 2)
(
  // clock, reset, enables
  input wire logic              CLK,
  input wire logic              RESET,
  input wire logic              PROGRAM_STORE_WRITE_ENABLE,
  input wire logic              PROGRAM_STORE_ERASE_ENABLE,
  // request
  input wire logic              CORE_DATA_SPACE,
  input wire logic              CORE_FROM_PROTECTED,
  input wire logic              CORE_FROM_DEBUG,
  input wire logic [ADDR_W-1:0] CORE_ADDR,
  input wire logic              CORE_DONE,
  input wire logic              CORE_REFUSED,
  // routes
  input wire logic              XDATA_RD,
  input wire logic [ADDR_W-1:0] XDATA_ADDR,
  input wire logic              FLASH_RD,
  input wire logic              FLASH_WR,
  input wire logic              FLASH_ER,
  input wire logic [ADDR_W-1:0] FLASH_ADDR,
  input wire logic [7:0]        LOCK_VALUE
);
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // address lies in a locked page
  function automatic logic lkd(logic [7:0] lv, logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:9] < ~lv) || (lv != 8'hFF && a[ADDR_W-1:9] == '1);
  endfunction
  sequence s_wr_tail;
    ##WRITE_CYC CORE_DONE;
  endsequence
  property p_wr_we; FLASH_WR |-> $past(PROGRAM_STORE_WRITE_ENABLE); endproperty
  a_wr_we: assert property (p_wr_we) else $error("write without enable");
  property p_er_both; FLASH_ER |-> $past(PROGRAM_STORE_WRITE_ENABLE && PROGRAM_STORE_ERASE_ENABLE); endproperty
  a_er_both: assert property (p_er_both) else $error("erase without enables");
  property p_wr_path; FLASH_WR |-> $past(CORE_DATA_SPACE) ##0 s_wr_tail; endproperty
  a_wr_path: assert property (p_wr_path) else $error("bad write path");
  property p_xd; XDATA_RD |-> CORE_DONE && !FLASH_RD && XDATA_ADDR == $past(CORE_ADDR); endproperty
  a_xd: assert property (p_xd) else $error("bad data-space read");
  property p_fetch; $fell(RESET) |=> FLASH_RD && FLASH_ADDR == '1; endproperty
  a_fetch: assert property (p_fetch) else $error("no lock fetch");
  property p_pages; (FLASH_RD || FLASH_WR || FLASH_ER) && !$past(CORE_FROM_PROTECTED) && !$past(RESET, 2)
    |-> !lkd(LOCK_VALUE, FLASH_ADDR); endproperty
  a_pages: assert property (p_pages) else $error("locked page reached");
  property p_dbg; (FLASH_RD || FLASH_WR || FLASH_ER) && $past(CORE_FROM_DEBUG) && !$past(RESET, 2)
    |-> !lkd(LOCK_VALUE, FLASH_ADDR); endproperty
  a_dbg: assert property (p_dbg) else $error("debug reached locked page");
  property p_quiet; CORE_REFUSED |-> CORE_DONE && !(FLASH_WR || FLASH_ER) ##1 !(FLASH_WR || FLASH_ER); endproperty
  a_quiet: assert property (p_quiet) else $error("refused yet stored");
endmodule
bind flash_guard flash_guard_checker #(.ADDR_W(ADDR_W), .WRITE_CYC(WRITE_CYC)) chk_inst (.CLK(CLK), .RESET(RESET),
  .PROGRAM_STORE_WRITE_ENABLE(PROGRAM_STORE_WRITE_ENABLE), .PROGRAM_STORE_ERASE_ENABLE(PROGRAM_STORE_ERASE_ENABLE),
  .CORE_DATA_SPACE(CORE_DATA_SPACE), .CORE_FROM_PROTECTED(CORE_FROM_PROTECTED), .CORE_FROM_DEBUG(CORE_FROM_DEBUG),
  .CORE_ADDR(CORE_ADDR), .CORE_DONE(CORE_DONE), .CORE_REFUSED(CORE_REFUSED), .XDATA_RD(XDATA_RD),
  .XDATA_ADDR(XDATA_ADDR), .FLASH_RD(FLASH_RD), .FLASH_WR(FLASH_WR), .FLASH_ER(FLASH_ER),
  .FLASH_ADDR(FLASH_ADDR), .LOCK_VALUE(LOCK_VALUE));

/* File: bench/flash_guard_tb_top.sv */
// Purpose: self-checking bench of the flash guard
// Assumes: lock byte FD, so pages 0, 1 and the lock page are locked
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module flash_guard_tb_top;
  localparam int LK = 'hFD;  // lock byte held in the array
  logic CLK, RESET, we, ee, req, ds, prot, dbg, done, refd, xrd, frd, fwr, fer;
  logic [1:0]  kind;
  logic [16:0] addr, xaddr, faddr;
  logic [7:0]  wdata, rdata, fwd, frdata, lockv;
  int          miscompares, checked, cycles;
  int          shadow [int];  // expected array contents
  flash_guard flash_guard_inst (.CLK(CLK), .RESET(RESET), .PROGRAM_STORE_WRITE_ENABLE(we),
    .PROGRAM_STORE_ERASE_ENABLE(ee), .CORE_REQ(req), .CORE_KIND(kind), .CORE_DATA_SPACE(ds),
    .CORE_FROM_PROTECTED(prot), .CORE_FROM_DEBUG(dbg), .CORE_ADDR(addr), .CORE_WDATA(wdata), .CORE_DONE(done),
    .CORE_REFUSED(refd), .CORE_RDATA(rdata), .XDATA_RD(xrd), .XDATA_ADDR(xaddr), .FLASH_RD(frd), .FLASH_WR(fwr),
    .FLASH_ER(fer), .FLASH_ADDR(faddr), .FLASH_WDATA(fwd), .FLASH_RDATA(frdata), .LOCK_VALUE(lockv));
  flash_model #(.LOCK(8'hFD)) flash_model_inst (.CLK(CLK), .rd(frd), .wr(fwr), .addr(faddr), .wdata(fwd),
    .rdata(frdata));
  // 200 MHz clock
  initial
  begin
    CLK = 0;
    forever #2.5 CLK = ~CLK;
  end
  // hang guard
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // page locked against untrusted code
  function automatic bit lk(int a);
    return (a >> 9) < 255 - LK || (LK != 255 && (a >> 9) == 255);
  endfunction
  // one request, checked against the integer model
  task automatic op(int w, int e, int k, int d, int p, int g, int a, int v);
    int n;
    bit bad, rf, sx, sr, sw, se;
    @(negedge CLK);
    {we, ee, kind, ds, prot, dbg, addr, wdata, req} = {1'(w), 1'(e), 2'(k), 1'(d), 1'(p), 1'(g), 17'(a), 8'(v), 1'b1};
    bad = lk(a) && (g || !p);
    rf = k == 2 ? !w || !d || bad : k == 3 ? !(w && e) || bad : k == 1 && !d && bad;
    {n, sx, sr, sw, se} = 0;
    do
    begin
      @(posedge CLK);
      #1 {sx, sr, sw, se} = {sx | xrd, sr | frd, sw | fwr, se | fer};
      n++;
    end while (done !== 1'b1 && n < 20);
    @(negedge CLK) req = 0;
    cmp(refd, rf);
    cmp(sx, k == 1 && d);
    cmp(sr, k == 1 && !d && !rf);
    cmp(sw, k == 2 && !rf);
    cmp(se, k == 3 && !rf);
    if (k == 1 && !d) cmp(rdata, rf ? 0 : shadow.exists(a) ? shadow[a] : (a & 255) ^ 'h5A);
    if (k == 2 && !rf) shadow[a] = v & 255;
  endtask
  initial
  begin
    {RESET, we, ee, req, ds, prot, dbg, kind, addr, wdata} = 1'b1 << 33;
    {miscompares, checked, cycles} = 0;
    void'($urandom(32'hc43f));
    repeat (4) @(negedge CLK);
    RESET = 0;
    repeat (3) @(posedge CLK);
    #1 cmp(lockv, LK);
    op(0, 0, 2, 1, 0, 0, 'h400, 'h11);
    op(1, 0, 2, 0, 0, 0, 'h400, 'h22);
    op(0, 0, 1, 0, 0, 0, 'h400, 0);
    op(1, 0, 2, 1, 0, 0, 'h400, 'h33);
    op(1, 0, 1, 0, 0, 0, 'h400, 0);
    op(1, 0, 3, 1, 0, 0, 'h600, 0);
    op(1, 1, 3, 1, 0, 0, 'h600, 0);
    op(1, 1, 3, 1, 0, 0, 'h200, 0);
    op(1, 0, 2, 1, 0, 0, 'h3FF, 'h44);
    op(0, 0, 1, 0, 0, 0, 'h3FF, 0);
    op(0, 0, 1, 0, 1, 0, 'h3FF, 0);
    op(0, 0, 1, 0, 1, 1, 'h000, 0);
    op(0, 0, 1, 0, 0, 0, 'h1FF00, 0);
    op(0, 0, 1, 1, 0, 1, 'h0100, 0);
    op(0, 0, 0, 0, 0, 0, 'h500, 0);
    repeat (80) op($urandom % 2, $urandom % 2, $urandom % 4, $urandom % 2, $urandom % 2, $urandom % 2,
      $urandom % 'h1FE00, $urandom % 256);
    wrap_up;
  end
endmodule
